// *** aau_pkg.sv ***
// register map, command codes and flag positions of the accumulator unit
// assumes a 32-bit AXI4-Lite master and one software-driven sequencer
`default_nettype none
package aau_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_ACC     = 8'h00;
   localparam logic [7:0] ADDR_STACK   = 8'h04;
   localparam logic [7:0] ADDR_OPND_LO = 8'h08;
   localparam logic [7:0] ADDR_OPND_HI = 8'h0C;
   localparam logic [7:0] ADDR_CMD     = 8'h10;
   localparam logic [7:0] ADDR_STATUS  = 8'h14;
   // ----------------------------------------
   // command word
   // ----------------------------------------
   localparam logic [3:0] OP_NONE    = 4'h0;
   localparam logic [3:0] OP_BCD_Q16 = 4'h1;
   localparam logic [3:0] OP_BCD_Q32 = 4'h2;
   localparam logic [3:0] OP_REAL_Q  = 4'h3;
   localparam logic [3:0] OP_BCD_INC = 4'h4;
   localparam logic [3:0] OP_BCD_DEC = 4'h5;
   localparam logic [3:0] OP_SUM16   = 4'h6;
   localparam logic [3:0] OP_DIFF16  = 4'h7;
   localparam logic [3:0] OP_PROD16  = 4'h8;
   localparam logic [3:0] OP_BINQ16  = 4'h9;
   localparam int CMD_IMM     = 8;
   localparam int CMD_PTR     = 9;
   localparam int CMD_PTR_BAD = 10;
   // ----------------------------------------
   // status flag positions
   // ----------------------------------------
   localparam int F_OVF    = 0;
   localparam int F_ZERO   = 1;
   localparam int F_BOR16  = 2;
   localparam int F_BOR32  = 3;
   localparam int F_CAR16  = 4;
   localparam int F_CAR32  = 5;
   localparam int F_NEG    = 6;
   localparam int F_BADPTR = 7;
   localparam int F_FVALID = 8;
   localparam int F_SIGN   = 9;
   localparam int F_UNDER  = 10;
   localparam int F_BADNUM = 11;
   localparam int F_REJECT = 12;
   localparam int NFLAGS   = 13;
   // ----------------------------------------
   // constants
   // ----------------------------------------
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam logic [31:0] WORD_RST    = 32'h0000_0000;
   localparam logic [31:0] BCD4_MAX    = 32'h0000_270F;
   localparam logic [31:0] TEN         = 32'h0000_000A;
   localparam logic [7:0]  EXP_ALL1    = 8'hFF;
   localparam logic [9:0]  EXP_BIAS    = 10'h07F;
   localparam logic [9:0]  EXP_BIAS_M1 = 10'h07E;
endpackage
`default_nettype wire

// *** aau_core.sv ***
// accumulator arithmetic unit with its AXI4-Lite register slave
// assumes the sequencer loads operands, then writes the command word
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RULE1] bcd 16 divide: quotient acc, remainder stack
// [RULE2] bcd 16 divisor: four digit word/constant
// [RULE3] bcd 32 divide: word pair, constant refused
// [RULE4] divides flag operand too large
// [RULE5] zero result sets zero flag
// [RULE6] negative result sets negative flag
// [RULE7] bcd ops flag non-bcd digits
// [RULE8] flags hold until same-flag op
// [RULE9] real divide of ieee accumulator
// [RULE10] real divide flags invalid pointer
// [RULE11] real divide drives float valid flag
// [RULE12] binary add flags wrong sign
// [RULE13] float underflow sets underflow flag
// [RULE14] real divide flags non-real operand
// [RULE15] bcd add one writes memory word
// [RULE16] bcd sub one writes memory word
// [RULE17] add low acc and word, 32-bit result
// [RULE18] carry flags for 16/32 bit add
// [RULE19] subtract word from accumulator
// [RULE20] borrow flags for 16/32 bit subtract
// [RULE21] 16x16 multiply into accumulator
// [RULE22] binary divide: quotient acc, remainder stack
// [RULE23] bcd digits four bits, low first
// [RULE24] zero divisor: overflow, nothing changes
module aau_core (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // ----------------------------------------
   // functions
   // ----------------------------------------
   // [RULE23] nibble per digit, lowest digit in bits 3:0
   function automatic logic bcd_ok(input logic [31:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (v[4*i+:4] > 4'h9) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   function automatic logic [31:0] bcd2bin(input logic [31:0] v);
      logic [31:0] acc;
      acc = 32'h0;
      for (int i = 7; i >= 0; i--) begin
         acc = 32'(acc * aau_pkg::TEN) + {28'h0, v[4*i+:4]};
      end
      return acc;
   endfunction

   function automatic logic [31:0] bin2bcd(input logic [31:0] v);
      logic [31:0] b;
      b = 32'h0;
      for (int i = 31; i >= 0; i--) begin
         for (int j = 0; j < 8; j++) begin
            if (b[4*j+:4] > 4'h4) begin
               b[4*j+:4] = b[4*j+:4] + 4'h3;
            end
         end
         b = {b[30:0], v[i]};
      end
      return b;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [31:0] acc_r, stk_r;
   logic [15:0] opl_r, oph_r;
   logic [10:0] cmd_r;
   logic        go_r;
   logic [aau_pkg::NFLAGS-1:0] flg_r;
   logic        awf_r, wf_r;
   logic [7:0]  awa_r;
   logic [31:0] wd_r;
   logic [3:0]  ws_r;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs  = s_axi_wvalid & s_axi_wready;
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire wfire = awf_r & wf_r;
   wire [31:0] wmask = {{8{ws_r[3]}}, {8{ws_r[2]}},
                        {8{ws_r[1]}}, {8{ws_r[0]}}};
   wire wa_acc = awa_r == aau_pkg::ADDR_ACC;
   wire wa_stk = awa_r == aau_pkg::ADDR_STACK;
   wire wa_opl = awa_r == aau_pkg::ADDR_OPND_LO;
   wire wa_oph = awa_r == aau_pkg::ADDR_OPND_HI;
   wire wa_cmd = awa_r == aau_pkg::ADDR_CMD;
   wire wa_sts = awa_r == aau_pkg::ADDR_STATUS;
   wire wa_ok  = wa_acc | wa_stk | wa_opl | wa_oph | wa_cmd | wa_sts;
   wire [31:0] wacc = (acc_r & ~wmask) | (wd_r & wmask);
   wire [31:0] wstk = (stk_r & ~wmask) | (wd_r & wmask);
   wire [31:0] wopl = ({16'h0, opl_r} & ~wmask) | (wd_r & wmask);
   wire [31:0] woph = ({16'h0, oph_r} & ~wmask) | (wd_r & wmask);
   wire cmd_go = wfire & wa_cmd;
   wire [31:0] rd_sel =
      (s_axi_araddr == aau_pkg::ADDR_ACC)     ? acc_r :
      (s_axi_araddr == aau_pkg::ADDR_STACK)   ? stk_r :
      (s_axi_araddr == aau_pkg::ADDR_OPND_LO) ? {16'h0, opl_r} :
      (s_axi_araddr == aau_pkg::ADDR_OPND_HI) ? {16'h0, oph_r} :
      (s_axi_araddr == aau_pkg::ADDR_CMD)     ? {21'h0, cmd_r} :
      {19'h0, flg_r};
   wire ra_ok = (s_axi_araddr == aau_pkg::ADDR_ACC) |
                (s_axi_araddr == aau_pkg::ADDR_STACK) |
                (s_axi_araddr == aau_pkg::ADDR_OPND_LO) |
                (s_axi_araddr == aau_pkg::ADDR_OPND_HI) |
                (s_axi_araddr == aau_pkg::ADDR_CMD) |
                (s_axi_araddr == aau_pkg::ADDR_STATUS);
   wire awf_nxt = (awf_r | aw_hs) & ~wfire;
   wire wf_nxt  = (wf_r | w_hs) & ~wfire;
   wire bv_nxt  = (s_axi_bvalid & ~s_axi_bready) | wfire;
   wire rv_nxt  = (s_axi_rvalid & ~s_axi_rready) | ar_hs;

   // ----------------------------------------
   // operand views
   // ----------------------------------------
   wire [3:0]  op    = cmd_r[3:0];
   wire [15:0] acc_lo = acc_r[15:0];
   wire [31:0] opw   = {oph_r, opl_r};
   wire [31:0] a_bin = bcd2bin(acc_r);
   wire [31:0] d16   = bcd2bin({16'h0, opl_r});
   wire [31:0] d32   = bcd2bin(opw);
   wire a_ok   = bcd_ok(acc_r);
   wire d16_ok = bcd_ok({16'h0, opl_r});
   wire d32_ok = bcd_ok(opw);
   wire [31:0] d16s = (d16 == 32'h0) ? 32'h1 : d16;
   wire [31:0] d32s = (d32 == 32'h0) ? 32'h1 : d32;
   wire [31:0] q16  = a_bin / d16s;
   wire [31:0] r16  = a_bin % d16s;
   wire [31:0] q32  = a_bin / d32s;
   wire [31:0] r32  = a_bin % d32s;
   wire [31:0] inc_b = (d16 == aau_pkg::BCD4_MAX) ? 32'h0 : d16 + 32'h1;
   wire [31:0] dec_b = (d16 == 32'h0) ? aau_pkg::BCD4_MAX : d16 - 32'h1;
   wire [31:0] inc_bcd = bin2bcd(inc_b);
   wire [31:0] dec_bcd = bin2bcd(dec_b);
   wire [16:0] sum17 = {1'b0, acc_lo} + {1'b0, opl_r};
   wire [32:0] dif33 = {1'b0, acc_r} - {17'h0, opl_r};
   wire [31:0] prod  = {16'h0, acc_lo} * {16'h0, opl_r};
   wire [31:0] bdiv  = (opl_r == 16'h0) ? 32'h1 : {16'h0, opl_r};
   wire [31:0] bq    = acc_r / bdiv;
   wire [31:0] br    = acc_r % bdiv;
   wire sum_serr = (acc_lo[15] == opl_r[15]) & (sum17[15] != acc_lo[15]);

   // ----------------------------------------
   // real divide, truncating mantissa
   // ----------------------------------------
   wire [7:0]  fea = acc_r[30:23];
   wire [7:0]  feb = opw[30:23];
   wire f_nan  = (fea == aau_pkg::EXP_ALL1) | (feb == aau_pkg::EXP_ALL1);
   wire fa_z   = fea == 8'h00;
   wire fb_z   = feb == 8'h00;
   wire [48:0] fq = {1'b1, acc_r[22:0], 25'h0} / {25'h0, 1'b1, opw[22:0]};
   wire [9:0]  fex = {2'h0, fea} - {2'h0, feb} +
                     (fq[25] ? aau_pkg::EXP_BIAS : aau_pkg::EXP_BIAS_M1);
   wire [22:0] fman = fq[25] ? fq[24:2] : fq[23:1];
   wire fsg    = acc_r[31] ^ opw[31];
   wire f_und  = fex[9] | (fex == 10'h0);
   wire f_ovr  = ~fex[9] & (fex >= {2'h0, aau_pkg::EXP_ALL1});

   // ----------------------------------------
   // execute
   // ----------------------------------------
   logic [31:0] n_acc, n_stk;
   logic [15:0] n_mem;
   logic        w_acc, w_stk, w_mem, bcdop, binop, realop;
   logic [aau_pkg::NFLAGS-1:0] upd, val;

   always_comb begin
      n_acc = acc_r;
      n_stk = stk_r;
      n_mem = opl_r;
      w_acc = 1'b0;
      w_stk = 1'b0;
      w_mem = 1'b0;
      bcdop = 1'b0;
      binop = 1'b0;
      realop = 1'b0;
      upd = '0;
      val = '0;
      unique case (op)
         aau_pkg::OP_BCD_Q16: begin
            bcdop = 1'b1;
            upd[aau_pkg::F_OVF] = 1'b1;
            upd[aau_pkg::F_BADNUM] = 1'b1;
            if (!a_ok || !d16_ok) begin
               val[aau_pkg::F_BADNUM] = 1'b1; // [RULE7]
            end else if (d16 == 32'h0 || q16 > aau_pkg::BCD4_MAX) begin
               val[aau_pkg::F_OVF] = 1'b1; // [RULE4] [RULE24]
            end else begin
               n_acc = bin2bcd(q16); // [RULE1] [RULE2]
               n_stk = bin2bcd(r16);
               w_acc = 1'b1;
               w_stk = 1'b1;
            end
         end
         aau_pkg::OP_BCD_Q32: begin
            bcdop = 1'b1;
            upd[aau_pkg::F_OVF] = 1'b1;
            upd[aau_pkg::F_BADNUM] = 1'b1;
            upd[aau_pkg::F_REJECT] = 1'b1;
            if (cmd_r[aau_pkg::CMD_IMM]) begin
               val[aau_pkg::F_REJECT] = 1'b1; // [RULE3]
            end else if (!a_ok || !d32_ok) begin
               val[aau_pkg::F_BADNUM] = 1'b1; // [RULE7]
            end else if (d32 == 32'h0) begin
               val[aau_pkg::F_OVF] = 1'b1; // [RULE4] [RULE24]
            end else begin
               n_acc = bin2bcd(q32); // [RULE3]
               n_stk = bin2bcd(r32);
               w_acc = 1'b1;
               w_stk = 1'b1;
            end
         end
         aau_pkg::OP_REAL_Q: begin
            realop = 1'b1;
            upd[aau_pkg::F_OVF] = 1'b1;
            upd[aau_pkg::F_BADPTR] = 1'b1;
            upd[aau_pkg::F_FVALID] = 1'b1;
            upd[aau_pkg::F_UNDER] = 1'b1;
            upd[aau_pkg::F_BADNUM] = 1'b1;
            if (cmd_r[aau_pkg::CMD_PTR] && cmd_r[aau_pkg::CMD_PTR_BAD]) begin
               val[aau_pkg::F_BADPTR] = 1'b1; // [RULE10]
            end else if (f_nan) begin
               val[aau_pkg::F_BADNUM] = 1'b1; // [RULE14]
            end else if (fb_z) begin
               val[aau_pkg::F_OVF] = 1'b1; // [RULE24]
            end else if (fa_z) begin
               n_acc = {fsg, 31'h0};
               w_acc = 1'b1;
            end else if (f_und) begin
               n_acc = {fsg, 31'h0};
               w_acc = 1'b1;
               val[aau_pkg::F_UNDER] = 1'b1; // [RULE13]
            end else if (f_ovr) begin
               val[aau_pkg::F_OVF] = 1'b1; // [RULE4]
            end else begin
               n_acc = {fsg, fex[7:0], fman}; // [RULE9]
               w_acc = 1'b1;
            end
            // [RULE11]
            val[aau_pkg::F_FVALID] = n_acc[30:23] != aau_pkg::EXP_ALL1;
         end
         aau_pkg::OP_BCD_INC, aau_pkg::OP_BCD_DEC: begin
            bcdop = 1'b1;
            upd[aau_pkg::F_BADNUM] = 1'b1;
            if (!d16_ok) begin
               val[aau_pkg::F_BADNUM] = 1'b1; // [RULE7]
            end else if (op == aau_pkg::OP_BCD_INC) begin
               n_mem = inc_bcd[15:0]; // [RULE15]
               w_mem = 1'b1;
            end else begin
               n_mem = dec_bcd[15:0]; // [RULE16]
               w_mem = 1'b1;
            end
         end
         aau_pkg::OP_SUM16: begin
            binop = 1'b1;
            upd[aau_pkg::F_CAR16] = 1'b1;
            upd[aau_pkg::F_CAR32] = 1'b1;
            upd[aau_pkg::F_SIGN] = 1'b1;
            n_acc = {15'h0, sum17}; // [RULE17]
            w_acc = 1'b1;
            val[aau_pkg::F_CAR16] = sum17[16]; // [RULE18]
            val[aau_pkg::F_SIGN] = sum_serr; // [RULE12]
         end
         aau_pkg::OP_DIFF16: begin
            binop = 1'b1;
            upd[aau_pkg::F_BOR16] = 1'b1;
            upd[aau_pkg::F_BOR32] = 1'b1;
            n_acc = dif33[31:0]; // [RULE19]
            w_acc = 1'b1;
            val[aau_pkg::F_BOR16] = acc_lo < opl_r; // [RULE20]
            val[aau_pkg::F_BOR32] = dif33[32];
         end
         aau_pkg::OP_PROD16: begin
            binop = 1'b1;
            n_acc = prod; // [RULE21]
            w_acc = 1'b1;
         end
         aau_pkg::OP_BINQ16: begin
            binop = 1'b1;
            upd[aau_pkg::F_OVF] = 1'b1;
            if (opl_r == 16'h0 || bq[31:16] != 16'h0) begin
               val[aau_pkg::F_OVF] = 1'b1; // [RULE4] [RULE24]
            end else begin
               n_acc = bq; // [RULE22]
               n_stk = br;
               w_acc = 1'b1;
               w_stk = 1'b1;
            end
         end
         default: begin
         end
      endcase
      // [RULE5]
      upd[aau_pkg::F_ZERO] = bcdop | binop | realop;
      if (op == aau_pkg::OP_BCD_INC || op == aau_pkg::OP_BCD_DEC) begin
         val[aau_pkg::F_ZERO] = n_mem == 16'h0;
      end else begin
         val[aau_pkg::F_ZERO] = (n_acc & {~realop, 31'h7FFF_FFFF}) == 32'h0;
      end
      // [RULE6]
      upd[aau_pkg::F_NEG] = binop | realop |
                            (bcdop & op != aau_pkg::OP_BCD_INC & op != aau_pkg::OP_BCD_DEC);
      val[aau_pkg::F_NEG] = ~bcdop & n_acc[31] & ~val[aau_pkg::F_ZERO];
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_r <= aau_pkg::WORD_RST;
         stk_r <= aau_pkg::WORD_RST;
         opl_r <= 16'h0;
         oph_r <= 16'h0;
         cmd_r <= 11'h0;
         go_r  <= 1'b0;
         flg_r <= '0;
      end else begin
         go_r <= cmd_go;
         if (cmd_go) begin
            cmd_r <= wd_r[10:0];
         end
         if (go_r && w_acc) begin
            acc_r <= n_acc;
         end else if (wfire && wa_acc) begin
            acc_r <= wacc;
         end
         if (go_r && w_stk) begin
            stk_r <= n_stk;
         end else if (wfire && wa_stk) begin
            stk_r <= wstk;
         end
         if (go_r && w_mem) begin
            opl_r <= n_mem;
         end else if (wfire && wa_opl) begin
            opl_r <= wopl[15:0];
         end
         if (wfire && wa_oph) begin
            oph_r <= woph[15:0];
         end
         if (go_r) begin
            flg_r <= (flg_r & ~upd) | (val & upd); // [RULE8]
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awf_r <= 1'b0;
         wf_r  <= 1'b0;
         awa_r <= 8'h0;
         wd_r  <= 32'h0;
         ws_r  <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= aau_pkg::RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= aau_pkg::RESP_OKAY;
      end else begin
         awf_r <= awf_nxt;
         wf_r  <= wf_nxt;
         if (aw_hs) begin
            awa_r <= s_axi_awaddr;
         end
         if (w_hs) begin
            wd_r <= s_axi_wdata;
            ws_r <= s_axi_wstrb;
         end
         s_axi_awready <= ~awf_nxt & ~bv_nxt & ~go_r;
         s_axi_wready  <= ~wf_nxt & ~bv_nxt & ~go_r;
         s_axi_bvalid  <= bv_nxt;
         if (wfire) begin
            s_axi_bresp <= wa_ok ? aau_pkg::RESP_OKAY : aau_pkg::RESP_SLVERR;
         end
         s_axi_arready <= ~rv_nxt;
         s_axi_rvalid  <= rv_nxt;
         if (ar_hs) begin
            s_axi_rdata <= ra_ok ? rd_sel : 32'h0;
            s_axi_rresp <= ra_ok ? aau_pkg::RESP_OKAY : aau_pkg::RESP_SLVERR;
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   wire ex_sum  = go_r & (op == aau_pkg::OP_SUM16);
   wire ex_dif  = go_r & (op == aau_pkg::OP_DIFF16);
   wire ex_prd  = go_r & (op == aau_pkg::OP_PROD16);
   wire ex_bq   = go_r & (op == aau_pkg::OP_BINQ16);
   wire ex_inc  = go_r & (op == aau_pkg::OP_BCD_INC);
   wire ex_q32  = go_r & (op == aau_pkg::OP_BCD_Q32);

   property p_sum;
      ex_sum |=> acc_r == {15'h0, $past(sum17)};
   endproperty
   a_sum: assert property (p_sum) else $error("sum result wrong"); // [RULE17]

   property p_carry;
      ex_sum |=> flg_r[aau_pkg::F_CAR16] == acc_r[16] && !flg_r[aau_pkg::F_CAR32];
   endproperty
   a_carry: assert property (p_carry) else $error("carry flag wrong"); // [RULE18]

   property p_zero;
      ex_sum |=> flg_r[aau_pkg::F_ZERO] == (acc_r == 32'h0);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong"); // [RULE5]

   property p_borrow;
      ex_dif |=> flg_r[aau_pkg::F_BOR32] == ($past(acc_r) < {16'h0, $past(opl_r)}) &&
                 flg_r[aau_pkg::F_NEG] == acc_r[31];
   endproperty
   a_borrow: assert property (p_borrow) else $error("borrow flag wrong"); // [RULE20]

   property p_prod;
      ex_prd |=> acc_r == 32'($past(acc_lo) * $past(opl_r));
   endproperty
   a_prod: assert property (p_prod) else $error("product wrong"); // [RULE21]

   property p_bq;
      ex_bq && opl_r != 16'h0 && bq[31:16] == 16'h0 |=>
         32'(acc_r * {16'h0, $past(opl_r)}) + stk_r == $past(acc_r);
   endproperty
   a_bq: assert property (p_bq) else $error("binary quotient wrong"); // [RULE22]

   property p_div0;
      ex_bq && opl_r == 16'h0 |=> $stable(acc_r) && $stable(stk_r) && flg_r[aau_pkg::F_OVF];
   endproperty
   a_div0: assert property (p_div0) else $error("zero divisor not refused"); // [RULE24]

   property p_inc;
      ex_inc && d16_ok |=> bcd2bin({16'h0, opl_r}) ==
         (($past(d16) == aau_pkg::BCD4_MAX) ? 32'h0 : $past(d16) + 32'h1);
   endproperty
   a_inc: assert property (p_inc) else $error("bcd add one wrong"); // [RULE15]

   property p_badbcd;
      ex_inc && !d16_ok |=> $stable(opl_r) && flg_r[aau_pkg::F_BADNUM];
   endproperty
   a_badbcd: assert property (p_badbcd) else $error("bad bcd not flagged"); // [RULE7]

   property p_keep;
      ex_prd |=> $stable(flg_r[aau_pkg::F_CAR16]) && $stable(flg_r[aau_pkg::F_OVF]);
   endproperty
   a_keep: assert property (p_keep) else $error("unrelated flag changed"); // [RULE8]

   property p_reject;
      ex_q32 && cmd_r[aau_pkg::CMD_IMM] |=> $stable(acc_r) && flg_r[aau_pkg::F_REJECT];
   endproperty
   a_reject: assert property (p_reject) else $error("constant not refused"); // [RULE3]

   c_sum:  cover property (ex_sum ##1 flg_r[aau_pkg::F_CAR16]);
   c_bq:   cover property (ex_bq ##1 !flg_r[aau_pkg::F_OVF]);
   c_real: cover property (go_r && op == aau_pkg::OP_REAL_Q ##1 flg_r[aau_pkg::F_FVALID]);
   c_wr:   cover property (cmd_go ##1 s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// *** aau_seq_model.sv ***
// sequencer model: register bus master
// assumes each task is entered just after a rising aclk edge
`timescale 1ns/1ps
`default_nettype none
module aau_seq_model (
   // clock
   input  wire logic        aclk,
   // write channels
   output var  logic [7:0]  s_axi_awaddr  = 8'h00,
   output var  logic        s_axi_awvalid = 1'b0,
   input  wire logic        s_axi_awready,
   output var  logic [31:0] s_axi_wdata   = 32'h0,
   output var  logic [3:0]  s_axi_wstrb   = 4'hF,
   output var  logic        s_axi_wvalid  = 1'b0,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output var  logic        s_axi_bready  = 1'b0,
   // read channels
   output var  logic [7:0]  s_axi_araddr  = 8'h00,
   output var  logic        s_axi_arvalid = 1'b0,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output var  logic        s_axi_rready  = 1'b0
);
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid);
      // released lines show the inverse, never a stale value
      s_axi_awaddr <= ~a;
      s_axi_wdata <= ~d;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench of the accumulator unit
// assumes aau_seq_model issues every bus cycle
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          error_cnt = 0;
   int          cmp_count = 0;

   aau_core      dut_u (.*);
   aau_seq_model m (.*);

   initial forever #10 aclk = ~aclk;

   task automatic chk(input string n, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask

   // load acc and operand, run one command, read back
   task automatic run(input logic [31:0] c, a, op, ea, es, el, input logic [12:0] fm, fv);
      m.wr(8'h00, a, rs);
      m.wr(8'h08, {16'h0, op[15:0]}, rs);
      m.wr(8'h0C, {16'h0, op[31:16]}, rs);
      m.wr(8'h10, c, rs);
      m.rd(8'h00, v, rs);
      chk("acc", v, ea);
      m.rd(8'h04, v, rs);
      chk("stack", v, es);
      m.rd(8'h08, v, rs);
      chk("word", v, el);
      m.rd(8'h14, v, rs);
      chk("flags", {19'h0, v[12:0] & fm}, {19'h0, fv});
      $display("test %h done", c);
   endtask

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      m.rd(8'h20, v, rs);
      chk("resp", {30'h0, rs}, {30'h0, aau_pkg::RESP_SLVERR});
      chk("rdata", v, 32'h0);
      m.wr(8'h20, 32'h1, rs);
      chk("bresp", {30'h0, rs}, {30'h0, aau_pkg::RESP_SLVERR});
      m.wr(8'h14, 32'hFFFF, rs);
      chk("bresp", {30'h0, rs}, {30'h0, aau_pkg::RESP_OKAY});
      $display("test bus done");
      run(32'h101, 32'h1234, 32'h12, 32'h102, 32'h10, 32'h12, 13'h843, 13'h0);
      run(32'h102, 32'h12345678, 32'h10000, 32'h12345678, 32'h10, 32'h0, 13'h1000, 13'h1000);
      run(32'h2, 32'h12345678, 32'h10000, 32'h1234, 32'h5678, 32'h0, 13'h3, 13'h0);
      run(32'h9, 32'h64, 32'h0, 32'h64, 32'h5678, 32'h0, 13'h1, 13'h1);
      run(32'h9, 32'h10005, 32'h10, 32'h1000, 32'h5, 32'h10, 13'h3, 13'h0);
      run(32'h6, 32'hABCDFFFF, 32'h1, 32'h10000, 32'h5, 32'h1, 13'h232, 13'h10);
      run(32'h106, 32'h7FFF, 32'h1, 32'h8000, 32'h5, 32'h1, 13'h200, 13'h200);
      run(32'h7, 32'h5, 32'h7, 32'hFFFFFFFE, 32'h5, 32'h7, 13'h4C, 13'h4C);
      run(32'h4, 32'h77, 32'h9999, 32'h77, 32'h5, 32'h0, 13'h802, 13'h2);
      run(32'h5, 32'h77, 32'h100, 32'h77, 32'h5, 32'h99, 13'h802, 13'h0);
      run(32'h4, 32'h77, 32'h1A, 32'h77, 32'h5, 32'h1A, 13'h800, 13'h800);
      run(32'h3, 32'h40C00000, 32'h40000000, 32'h40400000, 32'h5, 32'h0, 13'hDC2, 13'h100);
      run(32'h603, 32'h40C00000, 32'h40000000, 32'h40C00000, 32'h5, 32'h0, 13'h80, 13'h80);
      run(32'h3, 32'h800000, 32'h71800000, 32'h0, 32'h5, 32'h0, 13'h402, 13'h402);
      run(32'h8, 32'hFFFF, 32'hFFFF, 32'hFFFE0001, 32'h5, 32'hFFFF, 13'h402, 13'h400);
      run(32'h1, 32'h99999999, 32'h1, 32'h99999999, 32'h5, 32'h1, 13'h801, 13'h1);
      run(32'h3, 32'h7F800000, 32'h3F800000, 32'h7F800000, 32'h5, 32'h0, 13'h900, 13'h800);
      tally_and_finish();
   end

   // hang guard
   initial begin
      repeat (5000) @(posedge aclk);
      error_cnt++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
